// ### osp_pkg.sv
// package: register map, field positions, reset values, timing constants
package osp_pkg;
    // register byte offsets (all word aligned)
    localparam logic [11:0] REG_CLKSEL  = 12'h000;
    localparam logic [11:0] REG_STBYCFG = 12'h004;
    localparam logic [11:0] REG_GATE    = 12'h008;
    localparam logic [11:0] REG_CMD     = 12'h00C;
    localparam logic [11:0] REG_STATUS  = 12'h010;
    localparam logic [11:0] REG_BANKOFF = 12'h014;
    localparam logic [11:0] REG_CLKNET  = 12'h018;
    localparam logic [11:0] REG_GUARD   = 12'h01C;

    // master clock selection: 21 nominal settings, index 0 is 2.08 MHz
    localparam int          MCLK_CODES   = 21;
    localparam logic [4:0]  MCLK_DEFAULT = 5'h00;

    // standby configuration field positions
    localparam int STBY_BANDGAP_OFF = 0;
    localparam int STBY_POR_OFF     = 1;
    localparam int STBY_OSC_OFF     = 2;
    localparam int STBY_PLL_OFF     = 3;
    localparam int STBY_WAKE_EN     = 4;
    localparam int STBY_MON_EN      = 5;
    localparam int STBY_LOW_VOLT    = 6;
    localparam int STBY_REGULATOR   = 7;
    localparam logic [7:0] STBY_RESET = 8'h20;

    // static gate field positions
    localparam int GATE_OSC_EN = 0;
    localparam int GATE_PLL_EN = 1;
    localparam logic [1:0] GATE_RESET = 2'h1;

    // command bits (write one to act)
    localparam int CMD_CLKCFG_DONE = 0;

    // widths
    localparam int BANKS    = 8;
    localparam int CLK_NETS = 8;
    localparam int GUARDS   = 16;
    localparam int PLL_OUTS = 4;

    // reset pulse length after a droop
    localparam int RESET_PULSE_NS  = 100;
    localparam int CLK_PERIOD_NS   = 4;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RESET_PULSE_CNT = 8'(RESET_PULSE_CYC);

    typedef enum logic [1:0] {
        OSP_WAIT_SUPPLY,
        OSP_LOAD,
        OSP_USER,
        OSP_STANDBY
    } osp_state_t;
endpackage : osp_pkg

// ### osp_ctrl.sv
// oscillator, standby gating and power-on reset sequencer with apb slave
//
// Behaviour
// RULE1: oscillator enabled by config bit and user input
// RULE2: oscillator output feeds clock tree or pll
// RULE3: power up with 2.08 MHz master clock
// RULE4: switch frequency once clock bits received
// RULE5: no selection keeps 2.08 MHz default
// RULE6: master clock picks one of 21 settings
// RULE7: standby bandgap off kills analog blocks
// RULE8: por off in standby, detector stays
// RULE9: oscillator off statically or in standby
// RULE10: pll off statically or in standby
// RULE11: pll waits for low outputs before off
// RULE12: differential buffers disabled per bank
// RULE13: each primary clock net has enable
// RULE14: input guard switches buffers off
// RULE15: supplies up start nonvolatile config load
// RULE16: user mode monitoring chosen by config
// RULE17: droop resets and restarts supply monitoring
// RULE18: regulated parts monitor external supply too
// RULE19: bandgap off leaves low power detector
// RULE20: unsure supplies keep bandgap and por on
// RULE21: standby and wake act only when enabled
// RULE22: standby gates, wake restores resources
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module osp_ctrl (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // supply comparators (asynchronous)
    input  wire logic        core_above_rising_threshold,
    input  wire logic        io_above_rising_threshold,
    input  wire logic        ext_above_rising_threshold,
    input  wire logic        core_above_droop_threshold_bandgap_on,
    input  wire logic        core_above_droop_threshold_bandgap_off,
    // configuration download handshake
    output logic             nonvolatile_config_memory_load,
    input  wire logic        config_load_done,
    output logic             device_reset,
    // user core requests
    input  wire logic        user_osc_enable,
    input  wire logic        standby_request,
    input  wire logic        wakeup_request,
    // pll
    input  wire logic [3:0]  pll_out_level,
    output logic             pll_outputs_stop,
    output logic             pll_power_on,
    // analog enables
    output logic             bandgap_on,
    output logic             por_on,
    output logic             low_power_detector_on,
    output logic             osc_on,
    output logic             osc_to_pll_ref,
    output logic      [4:0]  master_clock_select,
    output logic      [7:0]  diff_bank_on,
    output logic      [7:0]  clock_net_on,
    output logic      [15:0] input_buffer_on
);
    // synchronisers for asynchronous inputs
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [3:0] pll1;
    logic [3:0] pll2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            pll1  <= 4'h0;
            pll2  <= 4'h0;
        end else begin
            sync1 <= {user_osc_enable, wakeup_request, standby_request,
                      core_above_droop_threshold_bandgap_off,
                      core_above_droop_threshold_bandgap_on,
                      ext_above_rising_threshold,
                      io_above_rising_threshold,
                      core_above_rising_threshold};
            sync2 <= sync1;
            pll1  <= pll_out_level;
            pll2  <= pll1;
        end
    end
    wire core_up    = sync2[0];
    wire io_up      = sync2[1];
    wire ext_up     = sync2[2];
    wire above_bg   = sync2[3];
    wire above_sram = sync2[4];
    wire stby_req   = sync2[5];
    wire wake_req   = sync2[6];
    wire osc_req    = sync2[7];

    // software visible registers
    logic [4:0]  clk_sel_pending;
    logic [4:0]  clk_sel;
    logic [7:0]  stby_cfg;
    logic [1:0]  gate;
    logic [7:0]  bank_on;
    logic [7:0]  net_on;
    logic [15:0] guard_on;
    logic        droop_seen;
    logic [7:0]  rst_cnt;
    osp_pkg::osp_state_t state;
    osp_pkg::osp_state_t next_state;

    wire wr     = psel && penable && pwrite;
    wire hit_cs = paddr == osp_pkg::REG_CLKSEL;
    wire hit_sc = paddr == osp_pkg::REG_STBYCFG;
    wire hit_gt = paddr == osp_pkg::REG_GATE;
    wire hit_cm = paddr == osp_pkg::REG_CMD;
    wire hit_st = paddr == osp_pkg::REG_STATUS;
    wire hit_bk = paddr == osp_pkg::REG_BANKOFF;
    wire hit_cn = paddr == osp_pkg::REG_CLKNET;
    wire hit_gd = paddr == osp_pkg::REG_GUARD;
    wire mapped = hit_cs | hit_sc | hit_gt | hit_cm | hit_st |
                  hit_bk | hit_cn | hit_gd;
    // out of range codes are dropped so the last legal one stays
    wire sel_ok = pwdata[4:0] < 5'(osp_pkg::MCLK_CODES);          // [RULE6]
    wire clk_cfg_done = wr && hit_cm && pwdata[osp_pkg::CMD_CLKCFG_DONE];
    wire in_standby = state == osp_pkg::OSP_STANDBY;
    wire wake_en  = stby_cfg[osp_pkg::STBY_WAKE_EN];
    // bandgap may only drop on low voltage parts
    wire bg_gate  = in_standby && stby_cfg[osp_pkg::STBY_BANDGAP_OFF] &&
                    stby_cfg[osp_pkg::STBY_LOW_VOLT];              // [RULE7]
    wire por_gate = in_standby && stby_cfg[osp_pkg::STBY_POR_OFF]; // [RULE8]
    wire osc_gate = in_standby && stby_cfg[osp_pkg::STBY_OSC_OFF]; // [RULE9]
    wire pll_gate = in_standby && stby_cfg[osp_pkg::STBY_PLL_OFF];
    wire supplies_up = core_up && io_up &&                   // [RULE18]
                       (ext_up || !stby_cfg[osp_pkg::STBY_REGULATOR]);
    // droop threshold switches to the bandgap off comparator when bandgap or por is gated
    wire droop = (bg_gate || por_gate) ? !above_sram :       // [RULE19]
                 !above_bg;                                  // [RULE17]
    wire monitor = stby_cfg[osp_pkg::STBY_MON_EN];                // [RULE16]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel_pending <= osp_pkg::MCLK_DEFAULT;
            clk_sel         <= osp_pkg::MCLK_DEFAULT;              // [RULE3]
            stby_cfg        <= osp_pkg::STBY_RESET;
            gate            <= osp_pkg::GATE_RESET;
            bank_on         <= 8'hFF;
            net_on          <= 8'hFF;
            guard_on        <= 16'hFFFF;
        end else begin
            if (wr && hit_cs && sel_ok)
                clk_sel_pending <= pwdata[4:0];
            // unwritten pending value stays the default code
            if (clk_cfg_done)
                clk_sel <= clk_sel_pending; // [RULE4] [RULE5]
            if (wr && hit_sc)
                stby_cfg <= pwdata[7:0];
            if (wr && hit_gt)
                gate <= pwdata[1:0];
            if (wr && hit_bk)
                bank_on <= ~pwdata[7:0];                           // [RULE12]
            if (wr && hit_cn)
                net_on <= pwdata[7:0];                             // [RULE13]
            if (wr && hit_gd)
                guard_on <= pwdata[15:0];                          // [RULE14]
        end
    end

    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            osp_pkg::OSP_WAIT_SUPPLY:
                if (supplies_up && rst_cnt == 8'h00)
                    next_state = osp_pkg::OSP_LOAD;                // [RULE15]
            osp_pkg::OSP_LOAD:
                if (!supplies_up)
                    next_state = osp_pkg::OSP_WAIT_SUPPLY;
                else if (config_load_done)
                    next_state = osp_pkg::OSP_USER;
            osp_pkg::OSP_USER:
                if (monitor && droop)
                    next_state = osp_pkg::OSP_WAIT_SUPPLY;         // [RULE17]
                else if (wake_en && stby_req)
                    next_state = osp_pkg::OSP_STANDBY; // [RULE21] [RULE22]
            osp_pkg::OSP_STANDBY:
                if ((monitor || !por_gate) && droop)
                    next_state = osp_pkg::OSP_WAIT_SUPPLY;         // [RULE19]
                else if (wake_en && wake_req)
                    next_state = osp_pkg::OSP_USER; // [RULE21] [RULE22]
            default:
                next_state = osp_pkg::OSP_WAIT_SUPPLY;
        endcase
    end

    wire restart = (state == osp_pkg::OSP_USER ||
                    state == osp_pkg::OSP_STANDBY) &&
                   next_state == osp_pkg::OSP_WAIT_SUPPLY;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= osp_pkg::OSP_WAIT_SUPPLY;
            rst_cnt    <= 8'h00;
            droop_seen <= 1'b0;
        end else begin
            state <= next_state;
            if (restart)
                rst_cnt <= osp_pkg::RESET_PULSE_CNT;
            else if (rst_cnt != 8'h00)
                rst_cnt <= rst_cnt - 8'h01;
            // set wins over a clearing write in the same cycle
            if (restart)
                droop_seen <= 1'b1;
            else if (wr && hit_st && pwdata[0])
                droop_seen <= 1'b0;
        end
    end

    // pll shut down waits for all outputs to read low
    wire pll_want_off = pll_gate || !gate[osp_pkg::GATE_PLL_EN]; // [RULE10]
    logic pll_pwr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pll_pwr <= 1'b0;
        else if (!pll_want_off && !bg_gate)
            pll_pwr <= 1'b1;
        else if (pll2 == 4'h0)
            pll_pwr <= 1'b0;                                       // [RULE11]
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bandgap_on            <= 1'b1;
            por_on                <= 1'b1;
            low_power_detector_on <= 1'b1;
            osc_on                <= 1'b0;
            osc_to_pll_ref        <= 1'b0;
            master_clock_select   <= osp_pkg::MCLK_DEFAULT;
            diff_bank_on          <= 8'h00;
            clock_net_on          <= 8'h00;
            input_buffer_on       <= 16'h0000;
            device_reset          <= 1'b1;
            nonvolatile_config_memory_load <= 1'b0;
            pll_outputs_stop      <= 1'b1;
            pll_power_on          <= 1'b0;
        end else begin
            bandgap_on            <= !bg_gate;                     // [RULE7]
            por_on                <= !bg_gate && !por_gate; // [RULE8] [RULE19]
            low_power_detector_on <= 1'b1;
            // user enable is a core pin, so only its synced copy is used
            osc_on                <= gate[osp_pkg::GATE_OSC_EN] &&
                                     osc_req &&
                                     !osc_gate && !bg_gate;  // [RULE1] [RULE9]
            osc_to_pll_ref        <= gate[osp_pkg::GATE_PLL_EN];    // [RULE2]
            master_clock_select   <= clk_sel;                      // [RULE6]
            diff_bank_on          <= bg_gate ? 8'h00 : bank_on;    // [RULE7]
            clock_net_on          <= net_on;                       // [RULE13]
            input_buffer_on       <= guard_on;                     // [RULE14]
            device_reset          <= state != osp_pkg::OSP_USER &&
                                     state != osp_pkg::OSP_STANDBY;
            nonvolatile_config_memory_load <=
                next_state == osp_pkg::OSP_LOAD;                   // [RULE15]
            pll_outputs_stop      <= pll_want_off || bg_gate;     // [RULE11]
            pll_power_on          <= pll_pwr;
        end
    end

    // apb read path, zero wait states
    wire [31:0] rd_status = {27'h0, pll_pwr, state == osp_pkg::OSP_STANDBY,
                             state == osp_pkg::OSP_USER, rst_cnt != 8'h00,
                             droop_seen};
    assign prdata = !(psel && !pwrite) ? 32'h0 :
                    hit_cs ? {27'h0, clk_sel_pending} :
                    hit_sc ? {24'h0, stby_cfg} :
                    hit_gt ? {30'h0, gate} :
                    hit_st ? rd_status :
                    hit_bk ? {24'h0, ~bank_on} :
                    hit_cn ? {24'h0, net_on} :
                    hit_gd ? {16'h0, guard_on} : 32'h0;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // checks
    a_pll_off_low: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(pll_pwr) |-> $past(pll2) == 4'h0)            // [RULE11]
        else $error("pll powered off with a high output");
    a_clk_waits_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(clk_sel) |-> $past(clk_cfg_done))          // [RULE4]
        else $error("master clock changed without config done");
    a_stby_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
        (state == osp_pkg::OSP_USER && !wake_en) |=>
        state != osp_pkg::OSP_STANDBY)                      // [RULE21]
        else $error("standby entered with wake feature off");
    a_droop_reset: assert property (@(posedge pclk) disable iff (!presetn)
        restart |=> ##1 device_reset)                        // [RULE17]
        else $error("droop did not raise reset");
    a_osc_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !osc_req |=> !osc_on)                                // [RULE1]
        else $error("oscillator ran with user enable low");
    a_bg_kills: assert property (@(posedge pclk) disable iff (!presetn)
        bg_gate |=> !bandgap_on && !por_on && !osc_on &&
        diff_bank_on == 8'h00)                              // [RULE7]
        else $error("bandgap off left analog blocks running");
    a_load_start: assert property (@(posedge pclk) disable iff (!presetn)
        (state == osp_pkg::OSP_WAIT_SUPPLY && next_state == osp_pkg::OSP_LOAD)
        |=> nonvolatile_config_memory_load)                 // [RULE15]
        else $error("config load not started");
    a_wake_restore: assert property (@(posedge pclk) disable iff (!presetn)
        (in_standby && wake_en && wake_req && !droop) |=>
        state == osp_pkg::OSP_USER)                          // [RULE22]
        else $error("wake request ignored");
    a_bank_follow: assert property (@(posedge pclk) disable iff (!presetn)
        !bg_gate |=> diff_bank_on == $past(bank_on))        // [RULE12]
        else $error("bank enables did not follow register");
    a_net_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> clock_net_on == $past(net_on))             // [RULE13]
        else $error("clock net enables did not follow register");
    a_droop_flag: assert property (@(posedge pclk) disable iff (!presetn)
        restart |=> droop_seen)                             // [RULE17]
        else $error("droop flag not set on restart");
endmodule : osp_ctrl
`default_nettype wire

// ### osp_user_model.sv
// user core logic model: osc enable, standby/wake levels, load, pll clocks
`timescale 1ns/100ps
`default_nettype none
module osp_user_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bench commands
    input  wire logic       want_osc,
    input  wire logic       want_standby,
    input  wire logic       want_wake,
    // design side
    input  wire logic       nonvolatile_config_memory_load,
    input  wire logic       pll_outputs_stop,
    output logic            user_osc_enable,
    output logic            standby_request,
    output logic            wakeup_request,
    output logic            config_load_done,
    output logic      [3:0] pll_out_level
);
    logic [3:0] load_cnt;
    logic [3:0] stop_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_osc_enable  <= 1'b0;
            standby_request  <= 1'b0;
            wakeup_request   <= 1'b0;
            config_load_done <= 1'b0;
            load_cnt         <= 4'h0;
            stop_cnt         <= 4'h0;
            pll_out_level    <= 4'h3;
        end else begin
            user_osc_enable  <= want_osc;
            standby_request  <= want_standby;
            wakeup_request   <= want_wake;
            // download takes a few cycles, not instant
            load_cnt <= !nonvolatile_config_memory_load ? 4'h0 :
                        (load_cnt == 4'h8) ? load_cnt : load_cnt + 4'h1;
            config_load_done <= nonvolatile_config_memory_load &&
                                (load_cnt == 4'h8);
            // clocks keep running ten cycles after stop, then all go low
            if (!pll_outputs_stop || stop_cnt != 4'hA) begin
                stop_cnt      <= pll_outputs_stop ? stop_cnt + 4'h1 : 4'h0;
                pll_out_level <= (pll_out_level == 4'h0) ? 4'h3 :
                    {pll_out_level[2:0], pll_out_level[3]};
            end else begin
                pll_out_level <= 4'h0;
            end
        end
    end
endmodule : osp_user_model
`default_nettype wire

// ### osc_standby_por_control_tb_top.sv
// testbench for the oscillator, standby and power-on reset controller
`timescale 1ns/100ps
`default_nettype none
module osc_standby_por_control_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic        core_up = 1'b0, io_up = 1'b0, ext_up = 1'b0;
    logic        droop_on = 1'b1, droop_off = 1'b1;
    logic        load, load_done, device_reset, user_osc, stby, wake;
    logic [3:0]  pll_lvl;
    logic        pll_stop, pll_pwr, bg_on, por_on, lpd_on, osc_on, osc_ref;
    logic [4:0]  mclk;
    logic [7:0]  bank_on, net_on;
    logic [15:0] guard_on;
    logic        want_osc = 1'b0, want_stby = 1'b0, want_wake = 1'b0;
    int          fails = 0;
    int          checked = 0;
    logic [31:0] rd_val;
    logic        rd_err;
    int          n;

    always #2 pclk = ~pclk;

    osp_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_above_rising_threshold(core_up),
        .io_above_rising_threshold(io_up),
        .ext_above_rising_threshold(ext_up),
        .core_above_droop_threshold_bandgap_on(droop_on),
        .core_above_droop_threshold_bandgap_off(droop_off),
        .nonvolatile_config_memory_load(load),
        .config_load_done(load_done), .device_reset(device_reset),
        .user_osc_enable(user_osc), .standby_request(stby),
        .wakeup_request(wake), .pll_out_level(pll_lvl),
        .pll_outputs_stop(pll_stop), .pll_power_on(pll_pwr),
        .bandgap_on(bg_on), .por_on(por_on), .low_power_detector_on(lpd_on),
        .osc_on(osc_on), .osc_to_pll_ref(osc_ref),
        .master_clock_select(mclk), .diff_bank_on(bank_on),
        .clock_net_on(net_on), .input_buffer_on(guard_on));

    osp_user_model PARTNER (.pclk(pclk), .presetn(presetn),
        .want_osc(want_osc), .want_standby(want_stby), .want_wake(want_wake),
        .nonvolatile_config_memory_load(load), .pll_outputs_stop(pll_stop),
        .user_osc_enable(user_osc), .standby_request(stby),
        .wakeup_request(wake), .config_load_done(load_done),
        .pll_out_level(pll_lvl));

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask : tick

    // one apb transfer; request held until pready seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("read data", rd_val, exp);
    endtask : rd

    task automatic conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    initial begin
        #(4 * 20000);
        fails++;
        conclude();
    end

    initial begin
        tick(5);
        chk("reset out", device_reset, 1'b1);
        presetn <= 1'b1;
        tick(2);
        rd(osp_pkg::REG_CLKSEL, 32'h0);
        rd(osp_pkg::REG_STBYCFG, 32'h20);
        rd(osp_pkg::REG_GATE, 32'h1);
        rd(osp_pkg::REG_CLKNET, 32'hFF);
        rd(osp_pkg::REG_GUARD, 32'hFFFF);
        tick(40);
        chk("load early", load, 1'b0);
        core_up <= 1'b1;
        io_up <= 1'b1;
        ext_up <= 1'b1;
        for (n = 0; n < 200 && load !== 1'b1; n++) tick(1);
        chk("load", load, 1'b1);
        chk("mclk power up", mclk, 5'h00);
        for (n = 0; n < 200 && device_reset !== 1'b0; n++) tick(1);
        chk("user", device_reset, 1'b0);
        rd(osp_pkg::REG_STATUS, 32'h4);
        // clock select: command with nothing chosen, bad code, top code
        wr(osp_pkg::REG_CMD, 32'h1);
        tick(3);
        chk("mclk default", mclk, osp_pkg::MCLK_DEFAULT);
        wr(osp_pkg::REG_CLKSEL, 32'h5);
        tick(3);
        chk("mclk pending", mclk, 5'h00);
        wr(osp_pkg::REG_CMD, 32'h1);
        tick(3);
        chk("mclk switch", mclk, 5'h05);
        wr(osp_pkg::REG_CLKSEL, 32'h15);
        wr(osp_pkg::REG_CMD, 32'h1);
        tick(3);
        chk("mclk bad code", mclk, 5'h05);
        wr(osp_pkg::REG_CLKSEL, 32'h14);
        wr(osp_pkg::REG_CMD, 32'h1);
        tick(3);
        chk("mclk top", mclk, 5'h14);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", rd_err, 1'b1);
        // dynamic gating from user logic
        wr(osp_pkg::REG_BANKOFF, 32'hA5);
        wr(osp_pkg::REG_CLKNET, 32'h3C);
        wr(osp_pkg::REG_GUARD, 32'h00FF);
        tick(2);
        chk("banks", bank_on, 8'h5A);
        chk("nets", net_on, 8'h3C);
        chk("guards", guard_on, 16'h00FF);
        chk("osc user off", osc_on, 1'b0);
        want_osc <= 1'b1;
        tick(8);
        chk("osc on", osc_on, 1'b1);
        wr(osp_pkg::REG_GATE, 32'h2);
        tick(2);
        chk("osc static off", osc_on, 1'b0);
        wr(osp_pkg::REG_GATE, 32'h3);
        tick(3);
        chk("pll on", pll_pwr, 1'b1);
        chk("pll ref", osc_ref, 1'b1);
        // standby ignored without wake feature enable
        wr(osp_pkg::REG_STBYCFG, 32'h6F);
        want_stby <= 1'b1;
        tick(10);
        chk("no standby", bg_on, 1'b1);
        want_stby <= 1'b0;
        // let the old request drain through the synchroniser first
        tick(4);
        wr(osp_pkg::REG_STBYCFG, 32'h7F);
        tick(4);
        want_stby <= 1'b1;
        tick(8);
        chk("bandgap off", bg_on, 1'b0);
        chk("por off", por_on, 1'b0);
        chk("detector", lpd_on, 1'b1);
        chk("osc stby", osc_on, 1'b0);
        chk("diff off", bank_on, 8'h00);
        chk("pll waits", pll_pwr, 1'b1);
        chk("pll stop", pll_stop, 1'b1);
        tick(24);
        chk("pll off", pll_pwr, 1'b0);
        want_stby <= 1'b0;
        want_wake <= 1'b1;
        tick(10);
        want_wake <= 1'b0;
        chk("bandgap back", bg_on, 1'b1);
        chk("osc back", osc_on, 1'b1);
        chk("banks back", bank_on, 8'h5A);
        // droop on a regulated part: load waits for the external supply
        wr(osp_pkg::REG_STBYCFG, 32'hA0);
        ext_up <= 1'b0;
        droop_on <= 1'b0;
        tick(4);
        droop_on <= 1'b1;
        tick(4);
        chk("droop reset", device_reset, 1'b1);
        rd(osp_pkg::REG_STATUS, 32'h13);
        tick(60);
        chk("ext blocks", load, 1'b0);
        ext_up <= 1'b1;
        for (n = 0; n < 300 && device_reset !== 1'b0; n++) tick(1);
        chk("user again", device_reset, 1'b0);
        // monitoring off: droop ignored
        wr(osp_pkg::REG_STBYCFG, 32'h00);
        droop_on <= 1'b0;
        tick(10);
        chk("no monitor", device_reset, 1'b0);
        conclude();
    end
endmodule : osc_standby_por_control_tb_top
`default_nettype wire
